// ==== logic/pkrx_device.sv ====
// Packet handler end: byte queue, receive filters, checksum, transmit.
// Demodulator and modulator are byte-wide logic on the same clock.
`include "pkrx_defs.svh"

module pkrx_device (
  input  wire logic        CLOCK,      // 10 MHz
  input  wire logic        SYS_RST,    // Synchronous, active high
  pkrx_if.dev              hst,        // Host link
  input  wire logic [7:0]  DEM_DATA,   // Received byte after bit sync
  input  wire logic        DEM_VALID,  // One-cycle byte strobe
  output logic      [7:0]  MOD_DATA,   // Byte to modulator
  output logic             MOD_VALID,  // Byte offered
  output logic             MOD_LAST,   // Final byte of packet
  input  wire logic        MOD_READY,  // Modulator takes byte
  input  wire logic        MOD_SENT,   // Pulse: final bit has left
  output logic             IRQ_PIN_0   // Receive completion
);

  logic [7:0]              mem_r [`PKRX_FIFO_DEPTH];
  logic [`PKRX_PTR_W-1:0]  wp_r;
  logic [`PKRX_PTR_W-1:0]  rp_r;
  logic [`PKRX_CNT_W-1:0]  cnt_r;
  logic                    q_empty;
  logic                    q_full;
  logic                    push;
  logic                    pop;
  logic [7:0]              push_data;

  pkrx_pkg::pkrx_rx_state_type rx_st_r;
  pkrx_pkg::pkrx_rx_state_type rx_st_nxt;
  logic [`PKRX_LEN_W-1:0]  rem_r;
  logic [`PKRX_LEN_W-1:0]  rem_nxt;
  logic                    need_len_r;
  logic                    need_len_nxt;
  logic                    addr_pend_r;
  logic                    addr_pend_nxt;
  logic                    unlim_r;
  logic                    unlim_nxt;
  logic [31:0]             sh_r;
  logic [31:0]             window;
  logic [31:0]             mask;
  logic                    sync_hit;
  logic                    addr_ok;
  logic                    body_end;
  logic [15:0]             rx_crc_r;
  logic [15:0]             rx_crc_fin;
  logic [7:0]              crc_hi_r;
  logic                    rx_push;
  logic                    ev_sync;
  logic                    ev_match;
  logic                    ev_discard;
  logic                    ev_complete;
  logic                    ev_pass;
  logic                    ev_flush;
  logic                    frame_match_r;
  logic                    check_passed_r;
  logic                    complete_r;

  pkrx_pkg::pkrx_tx_state_type tx_st_r;
  logic [`PKRX_LEN_W-1:0]  trem_r;
  logic                    tneed_len_r;
  logic                    tunlim_r;
  logic [15:0]             tx_crc_r;
  logic [15:0]             tx_crc_fin;
  logic                    tx_end;
  logic                    tx_fire;
  logic                    tx_done_r;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d,
                                           input logic alt);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r  = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ (alt ? `PKRX_POLY_ALT : `PKRX_POLY_CCITT);
      end
    end
    return r;
  endfunction

  // RL19: seed per polynomial
  function automatic logic [15:0] crc_seed(input logic alt);
    return alt ? `PKRX_SEED_ALT : `PKRX_SEED_CCITT;
  endfunction

  // RL19: CCITT result complemented
  assign rx_crc_fin = hst.cfg.check_poly_select ? rx_crc_r : ~rx_crc_r;
  assign tx_crc_fin = hst.cfg.check_poly_select ? tx_crc_r : ~tx_crc_r;

  // Byte queue, shared by receive and transmit
  assign q_empty   = (cnt_r == '0);
  assign q_full    = (cnt_r == `PKRX_CNT_FULL);
  // RL3: host reads in any mode
  assign pop       = (tx_fire || hst.fifo_rd) && !q_empty;
  // Receiver wins over a host write; a byte arriving into a full queue is lost
  assign push      = (rx_push || hst.fifo_wr) && !q_full;
  assign push_data = rx_push ? DEM_DATA : hst.fifo_wdata;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST || ev_flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= push_data;
        wp_r        <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // Sync search; zero bytes never occur in a legal pattern
  assign window = {sh_r[23:0], DEM_DATA};
  always_comb begin
    unique case (hst.cfg.sync_len)
      2'h0: mask = 32'h0000_00ff;
      2'h1: mask = 32'h0000_ffff;
      2'h2: mask = 32'h00ff_ffff;
      2'h3: mask = 32'hffff_ffff;
    endcase
  end
  // RL10: cleared history cannot match
  assign sync_hit = ((window ^ hst.cfg.sync_pattern) & mask) == 32'h0000_0000;
  // RL11: own id only
  // RL12: own or broadcast id
  assign addr_ok = (DEM_DATA == hst.cfg.own_node_id) ||
                   (hst.cfg.addr_filter_select == `PKRX_AF_BCAST &&
                    DEM_DATA == hst.cfg.broadcast_node_id);
  // RL13: every payload byte, address too
  assign rx_push = (rx_st_r == pkrx_pkg::R_BODY) && DEM_VALID;

  always_comb begin
    rx_st_nxt     = rx_st_r;
    rem_nxt       = rem_r;
    need_len_nxt  = need_len_r;
    addr_pend_nxt = addr_pend_r;
    unlim_nxt     = unlim_r;
    body_end      = 1'b0;
    ev_sync       = 1'b0;
    ev_match      = 1'b0;
    ev_discard    = 1'b0;
    ev_complete   = 1'b0;
    ev_pass       = 1'b0;
    ev_flush      = 1'b0;
    if (DEM_VALID) begin
      unique case (rx_st_r)
        pkrx_pkg::R_SEARCH: begin
          // RL8: nothing happens without a hit
          if (sync_hit) begin
            // RL9: start payload reception
            rx_st_nxt     = pkrx_pkg::R_BODY;
            ev_sync       = 1'b1;
            need_len_nxt  = hst.cfg.var_len;
            rem_nxt       = hst.cfg.payload_len_limit;
            unlim_nxt     = !hst.cfg.var_len && hst.cfg.payload_len_limit == '0;
            addr_pend_nxt = hst.cfg.addr_filter_select != `PKRX_AF_OFF;
            // RL14: match waits for address
            ev_match      = hst.cfg.addr_filter_select == `PKRX_AF_OFF;
          end
        end
        pkrx_pkg::R_BODY: begin
          if (need_len_r) begin
            // RL20: length byte loads counter
            need_len_nxt = 1'b0;
            rem_nxt      = {3'h0, DEM_DATA};
            // RL15: length must be below limit
            // RL16: limit 2047 never rejects
            if ({3'h0, DEM_DATA} >= hst.cfg.payload_len_limit) begin
              ev_discard = 1'b1;
            end else if (DEM_DATA == 8'h00) begin
              body_end = 1'b1;
            end
          end else begin
            // RL21: first byte after length or sync
            if (addr_pend_r) begin
              addr_pend_nxt = 1'b0;
              // RL14: shared match flag
              if (addr_ok) begin
                ev_match = 1'b1;
              end else begin
                ev_discard = 1'b1;
              end
            end
            if (!unlim_r) begin
              rem_nxt = rem_r - 1'b1;
              body_end = (rem_r == 11'h001);
            end
          end
          // RL22: back to search
          if (ev_discard) begin
            rx_st_nxt = pkrx_pkg::R_SEARCH;
          end else if (body_end && hst.cfg.check_enable_bit) begin
            rx_st_nxt = pkrx_pkg::R_CRC_HI;
          end else if (body_end) begin
            ev_complete = 1'b1;
            rx_st_nxt   = pkrx_pkg::R_SEARCH;
          end
        end
        pkrx_pkg::R_CRC_HI: rx_st_nxt = pkrx_pkg::R_CRC_LO;
        pkrx_pkg::R_CRC_LO: begin
          // RL18: compare, bytes not queued
          rx_st_nxt = pkrx_pkg::R_SEARCH;
          if ({crc_hi_r, DEM_DATA} == rx_crc_fin) begin
            ev_pass     = 1'b1;
            ev_complete = 1'b1;
          // RL2: keep bit holds bad packet
          end else if (hst.cfg.keep_bad_packet_bit) begin
            ev_complete = 1'b1;
          end else begin
            ev_flush = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST || hst.mode != pkrx_pkg::MODE_RX) begin
      rx_st_r     <= pkrx_pkg::R_SEARCH;
      rem_r       <= '0;
      need_len_r  <= 1'b0;
      addr_pend_r <= 1'b0;
      unlim_r     <= 1'b0;
      sh_r        <= '0;
      rx_crc_r    <= '0;
      crc_hi_r    <= '0;
    end else begin
      rx_st_r     <= rx_st_nxt;
      rem_r       <= rem_nxt;
      need_len_r  <= need_len_nxt;
      addr_pend_r <= addr_pend_nxt;
      unlim_r     <= unlim_nxt;
      if (DEM_VALID) begin
        sh_r <= (rx_st_nxt == pkrx_pkg::R_SEARCH && rx_st_r == pkrx_pkg::R_SEARCH) ?
                window : '0;
      end
      if (ev_sync) begin
        rx_crc_r <= crc_seed(hst.cfg.check_poly_select);
      end else if (rx_push) begin
        rx_crc_r <= crc_step(rx_crc_r, DEM_DATA, hst.cfg.check_poly_select);
      end
      if (DEM_VALID && rx_st_r == pkrx_pkg::R_CRC_HI) begin
        crc_hi_r <= DEM_DATA;
      end
    end
  end

  // Receive flags; a setting event wins over a clear
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || hst.mode != pkrx_pkg::MODE_RX) begin
      frame_match_r <= 1'b0;
    end else if (ev_match) begin
      frame_match_r <= 1'b1;
    end else if (ev_discard || ev_sync) begin
      frame_match_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      check_passed_r <= 1'b0;
    end else if (ev_pass) begin
      check_passed_r <= 1'b1;
    end else if (ev_sync) begin
      check_passed_r <= 1'b0;
    end
  end

  // RL1: level until queue empties or next sync hit
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      complete_r <= 1'b0;
    end else if (ev_complete) begin
      complete_r <= 1'b1;
    end else if (q_empty || ev_sync) begin
      complete_r <= 1'b0;
    end
  end

  // Transmit path; host supplies any length or address byte
  assign tx_end  = tneed_len_r ? (mem_r[rp_r] == 8'h00) : (!tunlim_r && trem_r == 11'h001);
  assign tx_fire = (tx_st_r == pkrx_pkg::T_BODY) && MOD_READY && !q_empty;

  always_comb begin
    MOD_VALID = 1'b0;
    MOD_LAST  = 1'b0;
    MOD_DATA  = mem_r[rp_r];
    unique case (tx_st_r)
      pkrx_pkg::T_BODY: begin
        MOD_VALID = !q_empty;
        MOD_LAST  = tx_end && !hst.cfg.check_enable_bit;
      end
      // RL17: checksum after message
      pkrx_pkg::T_CRC_HI: begin
        MOD_VALID = 1'b1;
        MOD_DATA  = tx_crc_fin[15:8];
      end
      pkrx_pkg::T_CRC_LO: begin
        MOD_VALID = 1'b1;
        MOD_LAST  = 1'b1;
        MOD_DATA  = tx_crc_fin[7:0];
      end
      default: ;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST || hst.mode != pkrx_pkg::MODE_TX) begin
      tx_st_r     <= pkrx_pkg::T_IDLE;
      trem_r      <= '0;
      tneed_len_r <= 1'b0;
      tunlim_r    <= 1'b0;
      tx_crc_r    <= '0;
      tx_done_r   <= 1'b0;
    end else begin
      unique case (tx_st_r)
        pkrx_pkg::T_IDLE: if (!q_empty) begin
          tx_st_r     <= pkrx_pkg::T_BODY;
          trem_r      <= hst.cfg.payload_len_limit;
          tneed_len_r <= hst.cfg.var_len;
          tunlim_r    <= !hst.cfg.var_len && hst.cfg.payload_len_limit == '0;
          tx_crc_r    <= crc_seed(hst.cfg.check_poly_select);
        end
        pkrx_pkg::T_BODY: if (tx_fire) begin
          tx_crc_r <= crc_step(tx_crc_r, mem_r[rp_r], hst.cfg.check_poly_select);
          if (tneed_len_r) begin
            tneed_len_r <= 1'b0;
            trem_r      <= {3'h0, mem_r[rp_r]};
          end else begin
            trem_r <= trem_r - 1'b1;
          end
          if (tx_end) begin
            tx_st_r <= hst.cfg.check_enable_bit ? pkrx_pkg::T_CRC_HI : pkrx_pkg::T_WAIT;
          end
        end
        pkrx_pkg::T_CRC_HI: if (MOD_READY) tx_st_r <= pkrx_pkg::T_CRC_LO;
        pkrx_pkg::T_CRC_LO: if (MOD_READY) tx_st_r <= pkrx_pkg::T_WAIT;
        // RL6: done only on modulator report
        pkrx_pkg::T_WAIT: if (MOD_SENT) begin
          tx_st_r   <= pkrx_pkg::T_DONE;
          tx_done_r <= 1'b1;
        end
        pkrx_pkg::T_DONE: ;
      endcase
    end
  end

  assign hst.fifo_rdata = mem_r[rp_r];
  // RL4: queue flags for streaming
  // One driver for the whole flag word
  assign hst.flags = '{queue_empty_flag:        q_empty,
                       queue_full_flag:         q_full,
                       queue_level_cross_flag:  cnt_r > {1'b0, hst.cfg.fifo_thresh},
                       rx_packet_complete_flag: complete_r,
                       check_passed_flag:       check_passed_r,
                       frame_match_flag:        frame_match_r,
                       tx_done_flag:            tx_done_r};
  assign IRQ_PIN_0                         = complete_r;

endmodule

// ==== logic/pkrx_defs.svh ====
// Constants of the receive filter and checksum packet handler.
// Included by the package and the design files; definitions only.
//
// Summary of operation
// RL1: Completion flag on irq pin 0 when ready
// RL2: Bad checksum flushes queue unless keep bit
// RL3: Queue readable in sleep and standby too
// RL4: Long payloads streamed via level, full, empty flags
// RL5: Host prefills, refills on level or empty
// RL6: Transmit done after final bit left modulator
// RL7: Host reads while non-empty, then drains remainder
// RL8: No sync pattern: discard, no flag
// RL9: Sync hit starts payload, raises match flag
// RL10: Host never programs a zero sync byte
// RL11: Select 01: accept only own node id
// RL12: Select 10: accept own or broadcast id
// RL13: Address byte kept; host supplies it on transmit
// RL14: Address checked after sync; one shared flag
// RL15: Variable length: length below limit, else discard
// RL16: Limit 2047 disables length filtering
// RL17: Transmit appends two checksum bytes when enabled
// RL18: Receive checks, flags, strips checksum bytes
// RL19: Poly select picks CCITT or alternate checksum
// RL20: Variable length: first byte loads length counter
// RL21: Address is second byte variable, first fixed
// RL22: After discard, resume sync search in receive
`ifndef PKRX_DEFS_SVH
`define PKRX_DEFS_SVH

`define PKRX_FIFO_DEPTH  64
`define PKRX_PTR_W       6
`define PKRX_CNT_W       7
`define PKRX_CNT_FULL    7'h40
`define PKRX_LEN_W       11
`define PKRX_LEN_OFF     11'h7ff
`define PKRX_AF_OFF      2'h0
`define PKRX_AF_NODE     2'h1
`define PKRX_AF_BCAST    2'h2
`define PKRX_POLY_CCITT  16'h1021
`define PKRX_POLY_ALT    16'h8005
`define PKRX_SEED_CCITT  16'h1d0f
`define PKRX_SEED_ALT    16'hffff
`define PKRX_BUF_DEPTH   2

`endif

// ==== logic/pkrx_pkg.sv ====
// Types shared by both ends of the packet handler link.
// Assumes pkrx_defs.svh is on the include path.
`include "pkrx_defs.svh"

package pkrx_pkg;

  typedef enum logic [1:0] {MODE_SLEEP, MODE_STDBY, MODE_RX, MODE_TX} pkrx_mode_type;

  typedef enum logic [1:0] {R_SEARCH, R_BODY, R_CRC_HI, R_CRC_LO} pkrx_rx_state_type;

  typedef enum logic [2:0] {T_IDLE, T_BODY, T_CRC_HI, T_CRC_LO, T_WAIT, T_DONE} pkrx_tx_state_type;

  typedef struct packed {
    logic [31:0]              sync_pattern;        // Last received byte in bits 7:0
    logic [1:0]               sync_len;            // Sync bytes minus one
    logic                     var_len;             // Variable length format
    logic [`PKRX_LEN_W-1:0]   payload_len_limit;
    logic [1:0]               addr_filter_select;
    logic [7:0]               own_node_id;
    logic [7:0]               broadcast_node_id;
    logic                     check_enable_bit;
    logic                     check_poly_select;
    logic                     keep_bad_packet_bit;
    logic [`PKRX_PTR_W-1:0]   fifo_thresh;
  } pkrx_cfg_type;

  typedef struct packed {
    logic queue_empty_flag;
    logic queue_full_flag;
    logic queue_level_cross_flag;
    logic rx_packet_complete_flag;
    logic check_passed_flag;
    logic frame_match_flag;
    logic tx_done_flag;
  } pkrx_flags_type;

endpackage

// ==== logic/pkrx_if.sv ====
// Link between the host end and the packet handler end.
// Both ends run on the same clock; no clocking here.
interface pkrx_if;
  pkrx_pkg::pkrx_mode_type  mode;
  pkrx_pkg::pkrx_cfg_type   cfg;
  logic                     fifo_wr;
  logic [7:0]               fifo_wdata;
  logic                     fifo_rd;
  logic [7:0]               fifo_rdata;
  pkrx_pkg::pkrx_flags_type flags;

  modport dev  (input mode, cfg, fifo_wr, fifo_wdata, fifo_rd, output fifo_rdata, flags);
  modport host (output mode, cfg, fifo_wr, fifo_wdata, fifo_rd, input fifo_rdata, flags);
endinterface

// ==== logic/pkrx_host.sv ====
// Host end: fills and drains the packet handler queue for its user.
// Same clock as the handler; a two-entry buffer absorbs user stalls.
`include "pkrx_defs.svh"

module pkrx_host (
  input  wire logic                    CLOCK,     // 10 MHz
  input  wire logic                    SYS_RST,   // Synchronous, active high
  pkrx_if.host                         dev,       // Handler link
  input  wire pkrx_pkg::pkrx_mode_type MODE,      // Requested chip mode
  input  wire pkrx_pkg::pkrx_cfg_type  CFG,       // Packet settings
  input  wire logic [7:0]              TX_DATA,   // Byte to send
  input  wire logic                    TX_VALID,  // Byte offered
  output logic                         TX_READY,  // Byte taken
  output logic      [7:0]              RX_DATA,   // Received byte
  output logic                         RX_VALID,  // Byte offered
  input  wire logic                    RX_READY,  // User takes byte
  output pkrx_pkg::pkrx_flags_type     STATUS     // Handler flags
);

  pkrx_pkg::pkrx_mode_type mode_r;
  pkrx_pkg::pkrx_cfg_type  cfg_r;
  logic [7:0]              buf_r [`PKRX_BUF_DEPTH];
  logic                    bwp_r;
  logic                    brp_r;
  logic [1:0]              bcnt_r;
  logic                    bpush;
  logic                    bpop;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      mode_r <= pkrx_pkg::MODE_STDBY;
      cfg_r  <= '0;
    end else begin
      mode_r <= MODE;
      cfg_r  <= CFG;
    end
  end

  assign dev.mode = mode_r;
  assign dev.cfg  = cfg_r;

  // RL5: write until level or full, resume below level
  // RL13: address byte comes from user data
  assign TX_READY       = mode_r != pkrx_pkg::MODE_RX && !dev.flags.queue_full_flag &&
                          !dev.flags.queue_level_cross_flag;
  assign dev.fifo_wr    = TX_VALID && TX_READY;
  assign dev.fifo_wdata = TX_DATA;

  // RL7: read while non-empty; pauses when empty
  // RL3: outside receive, drain only a completed packet
  // Keeps a transmit prefill made in standby in the queue
  assign bpush       = (mode_r == pkrx_pkg::MODE_RX ||
                        (mode_r != pkrx_pkg::MODE_TX && dev.flags.rx_packet_complete_flag)) &&
                       !dev.flags.queue_empty_flag && bcnt_r != 2'h2;
  assign dev.fifo_rd = bpush;
  assign bpop        = RX_VALID && RX_READY;
  assign RX_VALID    = bcnt_r != 2'h0;
  assign RX_DATA     = buf_r[brp_r];

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      bwp_r  <= 1'b0;
      brp_r  <= 1'b0;
      bcnt_r <= 2'h0;
    end else begin
      if (bpush) begin
        buf_r[bwp_r] <= dev.fifo_rdata;
        bwp_r        <= ~bwp_r;
      end
      if (bpop) begin
        brp_r <= ~brp_r;
      end
      if (bpush && !bpop) begin
        bcnt_r <= bcnt_r + 2'h1;
      end else if (bpop && !bpush) begin
        bcnt_r <= bcnt_r - 2'h1;
      end
    end
  end

  // RL4: flags visible to user for completion
  assign STATUS = dev.flags;

endmodule

// ==== verification/pkrx_props.sv ====
// Concurrent checks on the link between host end and handler end.
// Instanced by the bench beside the link; one clock, sync reset.
module pkrx_props (
  input wire logic                     CLOCK,    // Link clock
  input wire logic                     SYS_RST,  // Sync reset, active high
  input wire pkrx_pkg::pkrx_mode_type  mode,     // Registered mode
  input wire pkrx_pkg::pkrx_cfg_type   cfg,      // Registered settings
  input wire logic                     fifo_wr,  // Queue write strobe
  input wire logic                     fifo_rd,  // Queue read strobe
  input wire pkrx_pkg::pkrx_flags_type flags     // Handler flags
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  a_bad_check_silent: assert property (
    $rose(flags.rx_packet_complete_flag) |->
    flags.check_passed_flag || cfg.keep_bad_packet_bit || !cfg.check_enable_bit)
    else $error("completion raised on failed checksum");
  a_full_over_level: assert property (
    flags.queue_full_flag |-> flags.queue_level_cross_flag && !flags.queue_empty_flag)
    else $error("full flag without level flag");
  a_empty_no_level: assert property (
    flags.queue_empty_flag |-> !flags.queue_level_cross_flag && !flags.queue_full_flag)
    else $error("empty queue shows level or full");
  // Engines clear one edge after the mode leaves
  a_match_only_rx: assert property (
    (mode != pkrx_pkg::MODE_RX) [*2] |-> !flags.frame_match_flag)
    else $error("match flag outside receive");
  a_done_only_tx: assert property (
    (mode != pkrx_pkg::MODE_TX) [*2] |-> !flags.tx_done_flag)
    else $error("done flag outside transmit");
  a_read_not_empty: assert property (
    fifo_rd |-> !flags.queue_empty_flag)
    else $error("read from empty queue");
  a_no_read_tx: assert property (
    fifo_rd |-> mode != pkrx_pkg::MODE_TX)
    else $error("host read during transmit");
  a_write_not_full: assert property (
    fifo_wr |-> !flags.queue_full_flag)
    else $error("write into full queue");
  a_no_write_rx: assert property (
    fifo_wr |-> mode != pkrx_pkg::MODE_RX)
    else $error("host write during receive");
  a_write_fills: assert property (
    fifo_wr && flags.queue_empty_flag |=> !flags.queue_empty_flag)
    else $error("write left queue empty");
endmodule

// ==== verification/packet_rx_filter_crc_tb_top.sv ====
// Bench joining the host end and the handler end through the link.
// Drives demodulator, modulator and host user sides on one clock.
module packet_rx_filter_crc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // Case word: var, select, poly, keep, bad, sync, accept, byte0, byte1
  typedef struct packed {
    logic       v;
    logic [1:0] s;
    logic       p;
    logic       k;
    logic       bad;
    logic       sy;
    logic       e;
    logic [7:0] b0;
    logic [7:0] b1;
  } pkrx_case_type;

  logic                     clock = 1'h0;
  logic                     sys_rst = 1'h1;
  logic [7:0]               dem_data = 8'h00;
  logic                     dem_valid = 1'h0;
  logic [7:0]               mod_data;
  logic                     mod_valid;
  logic                     mod_last;
  logic                     mod_ready = 1'h0;
  logic                     mod_sent = 1'h0;
  logic                     irq;
  logic [7:0]               tx_data = 8'h00;
  logic                     tx_valid = 1'h0;
  logic                     tx_ready;
  logic [7:0]               rx_data;
  logic                     rx_valid;
  logic                     rx_ready = 1'h0;
  pkrx_pkg::pkrx_mode_type  mode = pkrx_pkg::MODE_STDBY;
  pkrx_pkg::pkrx_cfg_type   cfg = '0;
  pkrx_pkg::pkrx_flags_type st;
  int                       num_errors = 0;
  int                       checks = 0;
  pkrx_case_type            t;
  logic [15:0]              c;
  logic [7:0]               q [$];
  pkrx_case_type            tc [10] = '{24'h231234, 24'h261234, 24'h2f1234, 24'h22ff34,
    24'h43ff34, 24'h427734, 24'h001234, 24'h930244, 24'h920344, 24'ha30212};

  pkrx_if lnk ();

  pkrx_device u_pkrx_device (.CLOCK(clock), .SYS_RST(sys_rst), .hst(lnk.dev),
    .DEM_DATA(dem_data), .DEM_VALID(dem_valid), .MOD_DATA(mod_data), .MOD_VALID(mod_valid),
    .MOD_LAST(mod_last), .MOD_READY(mod_ready), .MOD_SENT(mod_sent), .IRQ_PIN_0(irq));
  pkrx_host u_pkrx_host (.CLOCK(clock), .SYS_RST(sys_rst), .dev(lnk.host), .MODE(mode),
    .CFG(cfg), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready), .STATUS(st));
  pkrx_props u_pkrx_props (.CLOCK(clock), .SYS_RST(sys_rst), .mode(lnk.mode),
    .cfg(lnk.cfg), .fifo_wr(lnk.fifo_wr), .fifo_rd(lnk.fifo_rd), .flags(lnk.flags));

  always #50 clock = ~clock;

  task automatic clk();
    @(posedge clock);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Bitwise, MSB first, over the bytes held in q
  function automatic logic [15:0] crc(input logic alt);
    logic [15:0] r;
    r = alt ? 16'hffff : 16'h1d0f;
    foreach (q[i]) begin
      r = r ^ {q[i], 8'h00};
      repeat (8) r = r[15] ? ((r << 1) ^ (alt ? 16'h8005 : 16'h1021)) : (r << 1);
    end
    return alt ? r : ~r;
  endfunction

  task automatic dem(input logic [7:0] b);
    dem_data = b;
    dem_valid = 1'h1;
    clk();
    dem_valid = 1'h0;
    clk();
  endtask

  task automatic rd(input logic [7:0] exp);
    int n;
    n = 0;
    while (rx_valid !== 1'h1 && n < 40) begin
      clk();
      n++;
    end
    chk({rx_valid, rx_data}, {1'h1, exp});
    rx_ready = 1'h1;
    clk();
    rx_ready = 1'h0;
    clk();
  endtask

  // Leftover bytes (kept length or address, or bytes taken before a flush) are pulled out here
  task automatic drain();
    repeat (8) begin
      rx_ready = rx_valid;
      clk();
    end
    rx_ready = 1'h0;
    clk();
  endtask

  task automatic wr(input logic [7:0] b);
    int n;
    tx_data = b;
    tx_valid = 1'h1;
    n = 0;
    while (tx_ready !== 1'h1 && n < 40) begin
      clk();
      n++;
    end
    chk(tx_ready, 1'h1);
    clk();
  endtask

  // Modulator stalls one cycle before each byte
  task automatic tk(input logic [7:0] b, input logic l);
    int n;
    mod_ready = 1'h0;
    clk();
    mod_ready = 1'h1;
    n = 0;
    while (mod_valid !== 1'h1 && n < 40) begin
      clk();
      n++;
    end
    chk({mod_valid, mod_last, mod_data}, {1'h1, l, b});
    clk();
  endtask

  initial begin
    #3000000;
    num_errors++;
    close_out();
  end

  initial begin
    cfg.sync_pattern = 32'h000000a5;
    cfg.payload_len_limit = 11'h003;
    cfg.own_node_id = 8'h12;
    cfg.broadcast_node_id = 8'hff;
    cfg.check_enable_bit = 1'h1;
    cfg.fifo_thresh = 6'h03;
    repeat (16) clk();
    sys_rst = 1'h0;
    foreach (tc[i]) begin
      t = tc[i];
      cfg.var_len = t.v;
      cfg.addr_filter_select = t.s;
      cfg.check_poly_select = t.p;
      cfg.keep_bad_packet_bit = t.k;
      mode = pkrx_pkg::MODE_RX;
      repeat (3) clk();
      q = '{t.b0, t.b1, 8'h56};
      c = crc(t.p) ^ {15'h0000, t.bad};
      dem(t.sy ? 8'ha5 : 8'h11);
      foreach (q[j]) dem(q[j]);
      dem(c[15:8]);
      dem(c[7:0]);
      repeat (2) clk();
      chk({irq, st.rx_packet_complete_flag}, {2{t.e}});
      chk(st.check_passed_flag, t.e & !t.bad);
      if (!t.bad) chk(st.frame_match_flag, t.e);
      mode = pkrx_pkg::MODE_STDBY;
      if (t.e) foreach (q[j]) rd(q[j]);
      drain();
      chk({irq, st.queue_empty_flag}, 2'h1);
    end
    cfg.var_len = 1'h0;
    cfg.payload_len_limit = 11'h004;
    cfg.check_poly_select = 1'h0;
    q = '{8'h01, 8'h23, 8'h45, 8'h67};
    c = crc(1'h0);
    foreach (q[j]) wr(q[j]);
    tx_valid = 1'h0;
    repeat (2) clk();
    chk({st.queue_level_cross_flag, st.queue_full_flag, tx_ready}, 3'h4);
    mode = pkrx_pkg::MODE_TX;
    q.push_back(c[15:8]);
    q.push_back(c[7:0]);
    foreach (q[j]) tk(q[j], j == 5);
    repeat (3) clk();
    chk(st.tx_done_flag, 1'h0);
    mod_sent = 1'h1;
    clk();
    mod_sent = 1'h0;
    clk();
    chk(st.tx_done_flag, 1'h1);
    close_out();
  end
endmodule
